// ---- test/apseq_drive_model.sv ----
// drive-side model: run command switch feeding the sequencer
`timescale 1ns/1ps
module apseq_drive_model (
  input  wire logic i_clk,
  input  wire logic i_run_req,
  output logic      o_run_cmd
);
  // run level follows the operator request one edge later
  always_ff @(posedge i_clk) begin
    o_run_cmd <= i_run_req;
  end
endmodule // apseq_drive_model

// ---- test/apseq_sva.sv ----
// checker: port-level properties of the stage sequencer
`timescale 1ns/1ps
module apseq_chk (
  input wire logic        I_CORE_CLK,
  input wire logic        I_RSTN,
  input wire logic        I_RUN_CMD,
  input wire logic        I_WOBBLE_EN,
  input wire logic        I_PID_EN,
  input wire logic [15:0] O_FREQ_REF,
  input wire logic [1:0]  O_DIR,
  input wire logic        O_ACTIVE,
  input wire logic [3:0]  O_MSTEP_SEL,
  input wire logic        O_USE_GEN_RAMP
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  ////////////////////////////////////////////////////////////////////
  // output codes and ranges
  property p_dir; O_DIR != 2'h3; endproperty
  a_dir: assert property (p_dir) else $error("illegal direction code");
  property p_fmax; O_FREQ_REF <= apseq_pkg::FREQ_MAX; endproperty
  a_fmax: assert property (p_fmax) else $error("frequency above limit");
  property p_stop; O_ACTIVE && O_DIR == 2'h0 |-> O_FREQ_REF == 16'h0000; endproperty
  a_stop: assert property (p_stop) else $error("stop stage not at zero");
  property p_move; $changed(O_FREQ_REF) |-> O_ACTIVE || $past(O_ACTIVE); endproperty
  a_move: assert property (p_move) else $error("reference moved while idle");
  ////////////////////////////////////////////////////////////////////
  // overrides, ramps and run command
  property p_ramp; $rose(O_ACTIVE) |-> O_USE_GEN_RAMP; endproperty
  a_ramp: assert property (p_ramp) else $error("general ramp not selected");
  property p_msel; O_USE_GEN_RAMP && $past(O_USE_GEN_RAMP) |-> O_MSTEP_SEL == 4'h0; endproperty
  a_msel: assert property (p_msel) else $error("step select leaked");
  property p_inh; (I_WOBBLE_EN || I_PID_EN) [*6] |=> !O_ACTIVE; endproperty
  a_inh: assert property (p_inh) else $error("active under override");
  property p_run; (!I_RUN_CMD) [*6] |=> !O_ACTIVE; endproperty
  a_run: assert property (p_run) else $error("active without run");
  // main scenarios
  c_start: cover property ($rose(O_ACTIVE));
  c_rev: cover property (O_ACTIVE && O_DIR == 2'h2);
  c_end: cover property ($fell(O_ACTIVE));
endmodule // apseq_chk
bind apseq_top apseq_chk i_chk (.I_CORE_CLK, .I_RSTN, .I_RUN_CMD, .I_WOBBLE_EN,
  .I_PID_EN, .O_FREQ_REF, .O_DIR, .O_ACTIVE, .O_MSTEP_SEL, .O_USE_GEN_RAMP);

// ---- test/tb.sv ----
// testbench: random and corner runs of the stage sequencer
`timescale 1ns/1ps
module tb;
  logic        clk, rstn, wr, rd, run_req, run, wob, pid, act, gen;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, ms0, fref, maxf;
  logic [3:0]  msel, msel_o;
  logic [1:0]  dir;
  logic [15:0] ef [16];
  logic [1:0]  ed [16];
  int          seed, n_fail, comparisons, k;
  apseq_top #(.TICK_CYCLES(10)) i_dut (.I_CORE_CLK(clk), .I_RSTN(rstn),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_RUN_CMD(run), .I_WOBBLE_EN(wob), .I_PID_EN(pid), .I_MS0_FREQ(ms0),
    .I_MSTEP_SEL(msel), .O_FREQ_REF(fref), .O_DIR(dir), .O_ACTIVE(act),
    .O_MSTEP_SEL(msel_o), .O_USE_GEN_RAMP(gen));
  apseq_drive_model i_drv (.i_clk(clk), .i_run_req(run_req), .o_run_cmd(run));
  ////////////////////////////////////////////////////////////////////
  // verdict and compare
  task automatic results();
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // expected stored frequency after clamp and coarse step
  function automatic logic [15:0] exp_freq(input logic [15:0] v);
    logic [15:0] c;
    c = (v > apseq_pkg::FREQ_MAX) ? apseq_pkg::FREQ_MAX : v;
    if (maxf > apseq_pkg::FREQ_HIRES_LIM) c = c - (c % 16'h000A);
    return c;
  endfunction
  // expected reference of stage n: stop stages give zero
  function automatic logic [15:0] fo(input int n);
    return (ed[n] == 2'h0) ? 16'h0000 : ef[n];
  endfunction
  ////////////////////////////////////////////////////////////////////
  // register port cycles
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    check(rdata, e);
  endtask
  // bounded wait for a stage, or for the first active cycle
  task automatic wait_ref(input logic [15:0] f, input logic [1:0] d, input bit first);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      if (first ? act === 1'b1 : (fref === f && dir === d)) break;
    end
    if (i == 400) begin
      n_fail++;
      results();
    end
    if (first) check(fref, f);
  endtask
  task automatic start(input logic [2:0] m);
    wreg(8'h00, {13'h0000, m});
    run_req <= 1'b1;
  endtask
  task automatic halt();
    run_req <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task automatic run_list(input logic [2:0] m);
    start(m);
    for (k = 0; k < 16; k++) wait_ref(fo(k), ed[k], 1'b0);
  endtask
  task automatic resume(input logic [2:0] m, input int s);
    start(m);
    wait_ref(fo(5), ed[5], 1'b0);
    halt();
    run_req <= 1'b1;
    wait_ref(fo(s), ed[s], 1'b1);
    halt();
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rstn, wr, rd, run_req, wob, pid, addr, wdata, msel} = '0;
    seed = 68;
    n_fail = 0;
    comparisons = 0;
    ms0 = 16'h0BB8;
    maxf = apseq_pkg::MAXFREQ_RST;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rreg(8'h01, apseq_pkg::MAXFREQ_RST);
    rreg(8'hFF, 16'h0000);
    wreg(8'h00, 16'h0001);
    wreg(8'h00, 16'h0007);
    rreg(8'h00, 16'h0001);
    wreg(8'h31, 16'h0002);
    wreg(8'h31, 16'h0003);
    rreg(8'h31, 16'h0002);
    for (k = 0; k < 16; k++) wreg(8'h20 + k[7:0], 16'h0000);
    start(3'h1);
    repeat (30) @(posedge clk);
    check(act, 1'b0);
    halt();
    wreg(8'h21, 16'hFFFF);
    rreg(8'h21, apseq_pkg::TIME_MAX);
    maxf = 16'h9C40;
    wreg(8'h01, maxf);
    // random stage table, stage 7 a stop stage
    for (k = 0; k < 16; k++) begin
      ef[k] = exp_freq(16'($random(seed)));
      ed[k] = (k == 7) ? 2'h0 : 2'h1 + 2'($random(seed) & 1);
      wreg(8'h10 + k[7:0], ef[k]);
      wreg(8'h20 + k[7:0], 16'h0003);
      wreg(8'h30 + k[7:0], {14'h0000, ed[k]});
    end
    rreg(8'h1F, ef[15]);
    ef[0] = ms0;
    wreg(8'h00, 16'h0000);
    msel <= 4'($random(seed)) | 4'h1;
    repeat (8) @(posedge clk);
    check(msel_o, msel);
    run_list(3'h1);
    repeat (45) @(posedge clk);
    check(act, 1'b0);
    halt();
    run_list(3'h2);
    wait_ref(fo(0), ed[0], 1'b0);
    check(msel_o, 4'h0);
    check(gen, 1'b1);
    wob <= 1'b1;
    repeat (8) @(posedge clk);
    check(act, 1'b0);
    wob <= 1'b0;
    pid <= 1'b1;
    repeat (8) @(posedge clk);
    check(act, 1'b0);
    pid <= 1'b0;
    halt();
    run_list(3'h3);
    repeat (45) @(posedge clk);
    check(act, 1'b1);
    check(fref, fo(15));
    halt();
    resume(3'h1, 5);
    resume(3'h4, 0);
    results();
  end
endmodule // tb

// ---- verilog/apseq_pkg.sv ----
// package: constants for the programmed-run stage sequencer
package apseq_pkg;
  localparam int          STAGE_NUM      = 16;
  localparam int          STAGE_W        = 4;
  localparam int          FREQ_W         = 16;   // 0.01 Hz units
  localparam int          TIME_W         = 16;   // 0.1 s units
  localparam int          MODE_W         = 3;
  localparam int          DIR_W          = 2;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 16;
  // frequency limits in 0.01 Hz, time limit in 0.1 s
  localparam logic [15:0] FREQ_MAX       = 16'hE9FC;  // 599.00 Hz
  localparam logic [15:0] FREQ_HIRES_LIM = 16'h7530;  // 300.00 Hz
  localparam logic [15:0] FREQ_COARSE    = 16'h000A;  // 0.1 Hz step
  localparam logic [15:0] TIME_MAX       = 16'hEA60;  // 6000.0 s
  // direction codes
  localparam logic [1:0]  DIR_STOP       = 2'h0;
  localparam logic [1:0]  DIR_FWD        = 2'h1;
  localparam logic [1:0]  DIR_REV        = 2'h2;
  // mode codes
  localparam logic [2:0]  MODE_OFF       = 3'h0;
  localparam logic [2:0]  MODE_RESUME_HI = 3'h3;
  localparam logic [2:0]  MODE_MAX       = 3'h6;
  // register map (word index = address)
  localparam logic [7:0]  ADR_CTRL       = 8'h00;  // [2:0] mode
  localparam logic [7:0]  ADR_MAXFREQ    = 8'h01;  // motor max freq
  localparam logic [7:0]  ADR_STATUS     = 8'h02;  // running/stage/done
  localparam logic [7:0]  ADR_FREQ_BASE  = 8'h10;  // 16 stage freqs
  localparam logic [7:0]  ADR_TIME_BASE  = 8'h20;  // 16 stage times
  localparam logic [7:0]  ADR_DIR_BASE   = 8'h30;  // 16 stage dirs
  localparam logic [15:0] MAXFREQ_RST    = 16'h1770;  // 60.00 Hz
  // tick timing: 0.1 s at 100 MHz
  localparam int          CLK_MHZ        = 100;
  localparam int          TICK_MS        = 100;
  localparam int          TICK_CYCLES    = TICK_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10,
    ST_DONE = 2'b11
  } seq_state_t;
endpackage

// ---- verilog/apseq_tick.sv ----
// tick generator: one-cycle pulse every period while enabled
`timescale 1ns/1ps
module apseq_tick #(
  parameter int PERIOD = 10000000
) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_run,
  output logic      o_tick
);
  logic [31:0] cnt_reg;
  logic        hit;

  assign hit = (cnt_reg == 32'(PERIOD - 1));

  // free counter, cleared while stopped so a stage starts fresh
  always_ff @(posedge i_clk) begin
    if (!i_rstn || !i_run) begin
      cnt_reg <= 32'h0;
      o_tick  <= 1'b0;
    end else begin
      cnt_reg <= hit ? 32'h0 : cnt_reg + 32'h1;
      o_tick  <= hit;
    end
  end
endmodule // apseq_tick

// ---- verilog/apseq_top.sv ----
// programmed-run stage sequencer with register port
`timescale 1ns/1ps
// Notes on behaviour
// R01 - mode 0 disables; modes 1,4 run list once then stop
// R02 - modes 2,5 repeat list forever
// R03 - modes 3,6 run once then hold last stage speed
// R04 - modes 1-3 resume at the unfinished stage after a stop
// R05 - modes 4-6 restart at stage 0 after a stop
// R06 - stage 0 freq from multi-speed 0; stages 1-15 own settings
// R07 - stage frequency accepts 0 to 599.00 Hz
// R08 - above 300 Hz max frequency, resolution falls to 0.1 Hz
// R09 - stage times accept 0 to 6000.0 s in 0.1 s steps
// R10 - direction 0 stop, 1 forward, 2 reverse
// R11 - inactive while wobble or PID is enabled
// R12 - zero stage durations keep the sequencer inactive
// R13 - multi-step speed inputs 1-4 ignored while enabled
// R14 - ramps use general accel/decel times while sequencing
// R15 - stages advance in order, each held for its duration
// R16 - continuous wraps 15 to 0; single cycle stops after 15
module apseq_top #(
  parameter int TICK_CYCLES = apseq_pkg::TICK_CYCLES
) (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RSTN,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [15:0] O_RDATA,
  input  wire logic        I_RUN_CMD,
  input  wire logic        I_WOBBLE_EN,
  input  wire logic        I_PID_EN,
  input  wire logic [15:0] I_MS0_FREQ,
  input  wire logic [3:0]  I_MSTEP_SEL,
  output logic      [15:0] O_FREQ_REF,
  output logic      [1:0]  O_DIR,
  output logic             O_ACTIVE,
  output logic      [3:0]  O_MSTEP_SEL,
  output logic             O_USE_GEN_RAMP
);
  ////////////////////////////////////////////////////////////////////
  // input synchronisers for pins
  logic [1:0] run_s_reg;
  logic [1:0] wob_s_reg;
  logic [1:0] pid_s_reg;
  logic [3:0] ms_s1_reg;
  logic [3:0] ms_s2_reg;
  logic       run_prev_reg;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      run_s_reg    <= 2'h0;
      wob_s_reg    <= 2'h0;
      pid_s_reg    <= 2'h0;
      ms_s1_reg    <= 4'h0;
      ms_s2_reg    <= 4'h0;
      run_prev_reg <= 1'b0;
    end else begin
      run_s_reg    <= {run_s_reg[0], I_RUN_CMD};
      wob_s_reg    <= {wob_s_reg[0], I_WOBBLE_EN};
      pid_s_reg    <= {pid_s_reg[0], I_PID_EN};
      ms_s1_reg    <= I_MSTEP_SEL;
      ms_s2_reg    <= ms_s1_reg;
      run_prev_reg <= run_s_reg[1];
    end
  end

  wire run_cmd  = run_s_reg[1];
  wire run_rise = run_s_reg[1] && !run_prev_reg;

  ////////////////////////////////////////////////////////////////////
  // settings registers
  logic [2:0]  mode_reg;
  logic [15:0] maxfreq_reg;
  logic [15:0] freq_mem [16];   // entry 0 unused: stage 0 follows multi-speed 0
  logic [15:0] time_mem [16];
  logic [1:0]  dir_mem  [16];

  wire [3:0] widx   = I_ADDR[3:0];
  wire [3:0] grp    = I_ADDR[7:4];
  wire wr_ctrl      = I_WR && (I_ADDR == apseq_pkg::ADR_CTRL);
  wire wr_maxf      = I_WR && (I_ADDR == apseq_pkg::ADR_MAXFREQ);
  wire wr_freq      = I_WR && (grp == apseq_pkg::ADR_FREQ_BASE[7:4]) && (widx != 4'h0);
  wire wr_time      = I_WR && (grp == apseq_pkg::ADR_TIME_BASE[7:4]);
  wire wr_dir       = I_WR && (grp == apseq_pkg::ADR_DIR_BASE[7:4]);
  wire hires_lost   = maxfreq_reg > apseq_pkg::FREQ_HIRES_LIM;
  // out-of-range frequency and time writes are clamped to the limit; mode writes with bits [2:0] = 7 are ignored, upper bits are dropped
  wire [15:0] f_clip = (I_WDATA > apseq_pkg::FREQ_MAX) ? apseq_pkg::FREQ_MAX : I_WDATA; // R07
  wire [15:0] f_wr   = hires_lost ? (f_clip - (f_clip % apseq_pkg::FREQ_COARSE)) : f_clip; // R08
  wire [15:0] t_wr   = (I_WDATA > apseq_pkg::TIME_MAX) ? apseq_pkg::TIME_MAX : I_WDATA; // R09
  wire        mode_ok = I_WDATA[2:0] <= apseq_pkg::MODE_MAX;

  // control and limit registers
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      mode_reg    <= apseq_pkg::MODE_OFF;
      maxfreq_reg <= apseq_pkg::MAXFREQ_RST;
    end else begin
      if (wr_ctrl && mode_ok)
        mode_reg <= I_WDATA[2:0];
      if (wr_maxf)
        maxfreq_reg <= I_WDATA;
    end
  end

  // per-stage tables
  genvar g;
  generate
    for (g = 0; g < apseq_pkg::STAGE_NUM; g++) begin : g_stage
      always_ff @(posedge I_CORE_CLK) begin
        if (!I_RSTN) begin
          time_mem[g] <= 16'h0;
          dir_mem[g]  <= apseq_pkg::DIR_STOP;
          freq_mem[g] <= 16'h0;
        end else begin
          if (wr_time && widx == 4'(g))
            time_mem[g] <= t_wr; // R09
          if (wr_dir && widx == 4'(g) && I_WDATA[1:0] != 2'h3)
            dir_mem[g] <= I_WDATA[1:0]; // R10
          if (g != 0 && wr_freq && widx == 4'(g))
            freq_mem[g] <= f_wr; // R06
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // enable qualification
  logic [15:0] any_time;
  always_comb begin
    any_time = 16'h0;
    for (int k = 0; k < apseq_pkg::STAGE_NUM; k++)
      any_time = any_time | time_mem[k];
  end
  wire times_zero = (any_time == 16'h0);
  wire seq_en = (mode_reg != apseq_pkg::MODE_OFF) && !wob_s_reg[1] && !pid_s_reg[1] // R01 R11
                && !times_zero; // R12
  wire resume_md = mode_reg <= apseq_pkg::MODE_RESUME_HI; // R04
  wire [1:0] msel = (mode_reg == 3'h1 || mode_reg == 3'h4) ? 2'd1 :
                    (mode_reg == 3'h2 || mode_reg == 3'h5) ? 2'd2 : 2'd3;

  ////////////////////////////////////////////////////////////////////
  // stage sequencer
  apseq_pkg::seq_state_t state_reg, state_next;
  logic [3:0]  stage_reg, stage_next;
  logic [15:0] elapsed_reg, elapsed_next;
  logic        tick;

  apseq_tick #(.PERIOD(TICK_CYCLES)) u_tick (
    .i_clk  (I_CORE_CLK),
    .i_rstn (I_RSTN),
    .i_run  (state_reg == apseq_pkg::ST_RUN),
    .o_tick (tick)
  );

  wire stage_end = (elapsed_reg >= time_mem[stage_reg]); // R15
  wire last      = (stage_reg == 4'hF);

  always_comb begin
    state_next   = state_reg;
    stage_next   = stage_reg;
    elapsed_next = elapsed_reg;
    case (state_reg)
      apseq_pkg::ST_IDLE: begin
        if (seq_en && run_cmd) begin
          state_next = apseq_pkg::ST_RUN;
          if (!resume_md) begin
            stage_next   = 4'h0; // R05
            elapsed_next = 16'h0;
          end
        end
      end
      apseq_pkg::ST_RUN: begin
        if (!seq_en || !run_cmd) begin
          state_next = apseq_pkg::ST_IDLE; // R04
        end else if (stage_end) begin
          elapsed_next = 16'h0;
          if (!last)
            stage_next = stage_reg + 4'h1; // R15
          else if (msel == 2'd2)
            stage_next = 4'h0; // R02 R16
          else if (msel == 2'd3)
            state_next = apseq_pkg::ST_HOLD; // R03
          else
            state_next = apseq_pkg::ST_DONE; // R01 R16
        end else if (tick) begin
          elapsed_next = elapsed_reg + 16'h1;
        end
      end
      apseq_pkg::ST_HOLD: begin
        if (!seq_en || !run_cmd)
          state_next = apseq_pkg::ST_IDLE;
      end
      apseq_pkg::ST_DONE: begin
        // finished cycle: a fresh run edge starts again
        if (!seq_en) begin
          state_next = apseq_pkg::ST_IDLE;
        end else if (run_rise) begin
          state_next   = apseq_pkg::ST_RUN;
          stage_next   = 4'h0;
          elapsed_next = 16'h0;
        end
      end
      default: state_next = apseq_pkg::ST_IDLE;
    endcase
    // after a finished or held cycle, resume starts anew
    if (state_reg != apseq_pkg::ST_RUN && state_next == apseq_pkg::ST_IDLE && state_reg != state_next) begin
      stage_next   = 4'h0;
      elapsed_next = 16'h0;
    end
  end

  // sequencer state
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      state_reg   <= apseq_pkg::ST_IDLE;
      stage_reg   <= 4'h0;
      elapsed_reg <= 16'h0;
    end else begin
      state_reg   <= state_next;
      stage_reg   <= stage_next;
      elapsed_reg <= elapsed_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reference outputs
  wire [15:0] cur_freq = (stage_reg == 4'h0) ? I_MS0_FREQ : freq_mem[stage_reg]; // R06
  wire [1:0]  cur_dir  = dir_mem[stage_reg];
  wire        driving  = (state_reg == apseq_pkg::ST_RUN) || (state_reg == apseq_pkg::ST_HOLD);
  wire        dir_run  = (cur_dir == apseq_pkg::DIR_FWD) || (cur_dir == apseq_pkg::DIR_REV); // R10

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      O_FREQ_REF     <= 16'h0;
      O_DIR          <= apseq_pkg::DIR_STOP;
      O_ACTIVE       <= 1'b0;
      O_MSTEP_SEL    <= 4'h0;
      O_USE_GEN_RAMP <= 1'b0;
    end else begin
      O_FREQ_REF     <= (driving && dir_run) ? cur_freq : 16'h0; // R10
      O_DIR          <= driving ? cur_dir : apseq_pkg::DIR_STOP;
      O_ACTIVE       <= driving;
      O_MSTEP_SEL    <= seq_en ? 4'h0 : ms_s2_reg; // R13
      O_USE_GEN_RAMP <= seq_en; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read port
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0;
    if (I_ADDR == apseq_pkg::ADR_CTRL)
      rd_mux = {13'h0, mode_reg};
    else if (I_ADDR == apseq_pkg::ADR_MAXFREQ)
      rd_mux = maxfreq_reg;
    else if (I_ADDR == apseq_pkg::ADR_STATUS)
      rd_mux = {8'h0, stage_reg, seq_en, state_reg, driving};
    else if (grp == apseq_pkg::ADR_FREQ_BASE[7:4])
      rd_mux = (widx == 4'h0) ? I_MS0_FREQ : freq_mem[widx];
    else if (grp == apseq_pkg::ADR_TIME_BASE[7:4])
      rd_mux = time_mem[widx];
    else if (grp == apseq_pkg::ADR_DIR_BASE[7:4])
      rd_mux = {14'h0, dir_mem[widx]};
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN)
      O_RDATA <= 16'h0;
    else
      O_RDATA <= I_RD ? rd_mux : 16'h0;
  end
endmodule // apseq_top
